/* File: rtl/gim_map.vh */
// gim_map.vh: register offsets, command codes, status bit positions and timing counts
// for the genset inhibit manager; included by the design files, definitions only.
`ifndef GIM_MAP_VH
`define GIM_MAP_VH

// ****************************************************************
// serial holding registers
// ****************************************************************
`define GIM_REG_PASSWORD     16'h0065
`define GIM_REG_COMMAND      16'h0066

// ****************************************************************
// command codes
// ****************************************************************
`define GIM_CMD_INHIBIT_A    16'h001F
`define GIM_CMD_INHIBIT_B    16'h0020
`define GIM_CMD_RELEASE      16'h0021

// ****************************************************************
// timing, in seconds of the seconds timebase
// ****************************************************************
`define GIM_SEQ_WINDOW_S     8'h05
`define GIM_SERIAL_HOLD_S    8'h1E

// ****************************************************************
// automatic-intervention status bit positions
// ****************************************************************
`define GIM_AI_CONTACT       0
`define GIM_AI_CLOCK         1
`define GIM_AI_LOAD_MGMT     2
`define GIM_AI_MAINS         3
`define GIM_AI_BRK_NOT_OPEN  4

// ****************************************************************
// load-taking status bit positions
// ****************************************************************
`define GIM_LT_CONTACT       0
`define GIM_LT_MAINS         1
`define GIM_LT_SERIAL        2
`define GIM_LT_BRK_NOT_OPEN  3
`define GIM_LT_SYNC          4
`define GIM_LT_SUPERVISOR    5

// ****************************************************************
// synchroniser reset levels, one bit per pin lane
// ****************************************************************
`define GIM_SYNC_IDLE        15'h0100

// ****************************************************************
// event codes on the event port
// ****************************************************************
`define GIM_EVT_LT_CONTACT   4'h1
`define GIM_EVT_LT_RELEASE   4'h2
`define GIM_EVT_LT_MAINS     4'h3
`define GIM_EVT_LT_SERIAL    4'h4
`define GIM_EVT_LT_BRK       4'h5
`define GIM_EVT_LT_SYNC      4'h6
`define GIM_EVT_LT_SUPER     4'h7
`define GIM_EVT_AI_MAINS_ON  4'h8
`define GIM_EVT_AI_MAINS_OFF 4'h9
`define GIM_EVT_AI_BRK_ON    4'hA
`define GIM_EVT_AI_BRK_OFF   4'hB

`endif

/* File: rtl/gim_serial_cmd.v */
// gim_serial_cmd.v: password/command sequence of the serial holding registers.
// assumes writes arrive as one-cycle strobes on ref_clk and sec_tick pulses once a second.
`timescale 1ns/1ps
`include "gim_map.vh"

module gim_serial_cmd (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        sec_tick,
   input  wire        reg_wr,
   input  wire [15:0] reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        serial_enabled,
   input  wire [15:0] password,
   output reg         serial_inhibit,
   output reg         serial_activate
);

   reg        armed;
   reg  [7:0] seq_secs;
   reg  [7:0] hold_secs;
   wire       code_ok;
   wire       is_inhibit;
   wire       is_release;

   assign code_ok    = reg_wr && (reg_addr == `GIM_REG_COMMAND) && armed && serial_enabled;
   assign is_inhibit = (reg_wdata == `GIM_CMD_INHIBIT_A) || (reg_wdata == `GIM_CMD_INHIBIT_B);
   assign is_release = (reg_wdata == `GIM_CMD_RELEASE);

   // ****************************************************************
   // sequence: password arms, command must follow within the window
   // ****************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         armed    <= 1'b0;
         seq_secs <= 8'h00;
      end else if (reg_wr && !serial_enabled) begin
         armed <= 1'b0;
      end else if (reg_wr && (reg_addr == `GIM_REG_PASSWORD)) begin
         armed    <= (reg_wdata == password);
         seq_secs <= 8'h00;
      end else if (code_ok) begin
         armed <= 1'b0;
      end else if (armed && sec_tick) begin
         if (seq_secs + 8'h01 >= `GIM_SEQ_WINDOW_S) begin
            armed <= 1'b0;
         end
         seq_secs <= seq_secs + 8'h01;
      end
   end

   // ****************************************************************
   // command hold: refreshed by each accepted inhibit command
   // ****************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         serial_inhibit  <= 1'b0;
         serial_activate <= 1'b0;
         hold_secs       <= 8'h00;
      end else begin
         serial_activate <= 1'b0;
         if (code_ok && is_inhibit) begin
            serial_inhibit  <= 1'b1;
            serial_activate <= 1'b1;
            hold_secs       <= 8'h00;
         end else if (code_ok && is_release) begin
            serial_inhibit <= 1'b0;
         end else if (serial_inhibit && sec_tick) begin
            if (hold_secs + 8'h01 >= `GIM_SERIAL_HOLD_S) begin
               serial_inhibit <= 1'b0;
            end
            hold_secs <= hold_secs + 8'h01;
         end
      end
   end

endmodule

/* File: rtl/gim_inhibit_manager.v */
// gim_inhibit_manager.v: top of the genset inhibit manager; combines inhibition sources.
// assumes plant and contact inputs come from pins (synchronised here), the serial port
// delivers register writes on ref_clk, and sec_tick is a ref_clk-domain one-second pulse.
`timescale 1ns/1ps
`include "gim_map.vh"

// Summary of operation
// - load management request stops surplus generators via auto-intervention inhibition
// - parallel-only plant, mains fail: open breaker, after wait inhibit until mains good
// - other breaker stuck closed with option: block/open breaker, stop, log both edges
// - one status flag per auto-intervention source, five sources
// - load-taking inhibition acts in auto, test and remote start, no anomaly needed
// - inhibition with breaker closed opens it, asserting power ramp-down with the open command when possible
// - log one release event when overall load-taking inhibition clears
// - contact input active holds load-taking inhibition and logs contact activation
// - serial commands accepted only while the enable input is active, if configured
// - password then command within five seconds, otherwise sequence rejected
// - codes 31 or 32 inhibit and open breaker, code 33 releases
// - serial inhibit lasts thirty seconds, logged; host resends about every 25 seconds
// - parallel-only plant, mains fail: open breaker now, inhibit until mains good, log
// - other breaker stuck closed with option: inhibit own breaker closure, log
// - supervisory board request inhibits load taking, opens breakers, logs
// - synchronisation in progress with own breaker open inhibits load taking, logs
// - one status flag per load-taking source, six sources
module gim_inhibit_manager (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        sec_tick,
   input  wire        reg_wr,
   input  wire [15:0] reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire [15:0] password,
   input  wire        serial_enable_configured,
   input  wire        serial_command_enable_input,
   input  wire        load_inhibit_input_function,
   input  wire        contact_ai_inhibit,
   input  wire        clock_ai_inhibit,
   input  wire        load_mgmt_request,
   input  wire        parallel_only_plant,
   input  wire        mains_in_tolerance,
   input  wire [7:0]  mains_fail_wait_s,
   input  wire        brk_not_open_option,
   input  wire        other_breaker_stuck,
   input  wire        supervisor_request,
   input  wire        sync_in_progress,
   input  wire        generator_breaker_closed,
   input  wire        ramp_possible,
   input  wire        auto_mode,
   input  wire        test_mode,
   input  wire        remote_start_mode,
   output reg         ai_inhibit,
   output reg         lt_inhibit,
   output reg  [4:0]  ai_status,
   output reg  [5:0]  lt_status,
   output reg         generator_breaker_open_cmd,
   output reg         power_ramp_down,
   output reg         event_valid,
   output reg  [3:0]  event_code
);

   // ****************************************************************
   // pin synchronisers, one generate lane per input
   // ****************************************************************
   localparam NSYNC = 15;
   // lanes reset to their idle level: a good mains must not read as a failure after reset
   localparam [NSYNC-1:0] SYNC_IDLE = `GIM_SYNC_IDLE;
   wire [NSYNC-1:0] pin_raw;
   wire [NSYNC-1:0] pin_s;
   assign pin_raw = {serial_command_enable_input, load_inhibit_input_function,
                     contact_ai_inhibit, clock_ai_inhibit, load_mgmt_request,
                     parallel_only_plant, mains_in_tolerance, brk_not_open_option,
                     other_breaker_stuck, supervisor_request, sync_in_progress,
                     generator_breaker_closed, auto_mode, test_mode, remote_start_mode};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         reg meta;
         reg stab;
         always @(posedge ref_clk) begin
            if (rst) begin
               meta <= SYNC_IDLE[gi];
               stab <= SYNC_IDLE[gi];
            end else begin
               meta <= pin_raw[gi];
               stab <= meta;
            end
         end
         assign pin_s[gi] = stab;
      end
   endgenerate

   wire s_ser_en   = pin_s[14];
   wire s_lt_cont  = pin_s[13];
   wire s_ai_cont  = pin_s[12];
   wire s_ai_clk   = pin_s[11];
   wire s_lm_req   = pin_s[10];
   wire s_par_only = pin_s[9];
   wire s_mains_ok = pin_s[8];
   wire s_brk_opt  = pin_s[7];
   wire s_stuck    = pin_s[6];
   wire s_super    = pin_s[5];
   wire s_sync     = pin_s[4];
   wire s_gb_cl    = pin_s[3];
   wire s_auto     = pin_s[2];
   wire s_test     = pin_s[1];
   wire s_remote   = pin_s[0];

   // ****************************************************************
   // serial command path
   // ****************************************************************
   wire serial_enabled;
   wire serial_inhibit;
   wire serial_activate;

   assign serial_enabled = !serial_enable_configured || s_ser_en;

   gim_serial_cmd u_serial (
      .ref_clk         (ref_clk),
      .rst             (rst),
      .sec_tick        (sec_tick),
      .reg_wr          (reg_wr),
      .reg_addr        (reg_addr),
      .reg_wdata       (reg_wdata),
      .serial_enabled  (serial_enabled),
      .password        (password),
      .serial_inhibit  (serial_inhibit),
      .serial_activate (serial_activate)
   );

   // ****************************************************************
   // mains failure wait before stopping the generator
   // ****************************************************************
   wire       mains_failed;
   reg  [7:0] mains_secs;
   reg        mains_ai;

   assign mains_failed = s_par_only && !s_mains_ok;

   always @(posedge ref_clk) begin
      if (rst) begin
         mains_secs <= 8'h00;
         mains_ai   <= 1'b0;
      end else if (!mains_failed) begin
         mains_secs <= 8'h00;
         mains_ai   <= 1'b0;
      end else if (!mains_ai) begin
         if (mains_secs >= mains_fail_wait_s) begin
            mains_ai <= 1'b1;
         end else if (sec_tick) begin
            mains_secs <= mains_secs + 8'h01;
         end
      end
   end

   // ****************************************************************
   // source flags and overall inhibitions
   // ****************************************************************
   // the wait input is sampled directly: it is a configuration value, held steady
   wire       any_auto = s_auto || s_test || s_remote;
   wire       stuck_on = s_brk_opt && s_stuck;
   wire [4:0] next_ai_status;
   wire [5:0] next_lt_status;
   wire       next_ai_inhibit;
   wire       next_lt_inhibit;

   assign next_ai_status[`GIM_AI_CONTACT]      = s_ai_cont;
   assign next_ai_status[`GIM_AI_CLOCK]        = s_ai_clk;
   assign next_ai_status[`GIM_AI_LOAD_MGMT]    = s_lm_req;
   assign next_ai_status[`GIM_AI_MAINS]        = mains_ai;
   assign next_ai_status[`GIM_AI_BRK_NOT_OPEN] = stuck_on;

   assign next_lt_status[`GIM_LT_CONTACT]      = s_lt_cont;
   assign next_lt_status[`GIM_LT_MAINS]        = mains_failed;
   assign next_lt_status[`GIM_LT_SERIAL]       = serial_inhibit;
   assign next_lt_status[`GIM_LT_BRK_NOT_OPEN] = stuck_on;
   assign next_lt_status[`GIM_LT_SYNC]         = s_sync && !s_gb_cl;
   assign next_lt_status[`GIM_LT_SUPERVISOR]   = s_super;

   // ai acts in auto only; sources still show in status in any mode
   assign next_ai_inhibit = s_auto && (|next_ai_status);
   assign next_lt_inhibit = any_auto && (|next_lt_status);

   always @(posedge ref_clk) begin
      if (rst) begin
         ai_status  <= 5'h00;
         lt_status  <= 6'h00;
         ai_inhibit <= 1'b0;
         lt_inhibit <= 1'b0;
      end else begin
         ai_status  <= next_ai_status;
         lt_status  <= next_lt_status;
         ai_inhibit <= next_ai_inhibit;
         lt_inhibit <= next_lt_inhibit;
      end
   end

   // ****************************************************************
   // breaker opening with optional ramp-down
   // ****************************************************************
   // mains failure opens at once: no time to ramp against a dead grid
   always @(posedge ref_clk) begin
      if (rst) begin
         generator_breaker_open_cmd <= 1'b0;
         power_ramp_down            <= 1'b0;
      end else if (lt_inhibit && s_gb_cl) begin
         if (lt_status[`GIM_LT_MAINS] || !ramp_possible) begin
            generator_breaker_open_cmd <= 1'b1;
            power_ramp_down            <= 1'b0;
         end else begin
            generator_breaker_open_cmd <= 1'b1;
            power_ramp_down            <= 1'b1;
         end
      end else begin
         generator_breaker_open_cmd <= lt_inhibit;
         power_ramp_down            <= 1'b0;
      end
   end

   // ****************************************************************
   // event log: one event per cycle, highest priority first
   // ****************************************************************
   // simultaneous edges are queued as pending bits so none is lost
   localparam NEV = 11;
   reg  [NEV-1:0] pend;
   reg  [5:0]     lt_prev;
   reg  [1:0]     ai_prev;
   reg            lt_all_prev;
   wire [5:0]     lt_rise = lt_status & ~lt_prev;
   wire [NEV-1:0] raise;
   reg  [NEV-1:0] take;
   reg  [3:0]     next_code;
   integer        k;

   assign raise = {ai_prev[1] & ~ai_status[`GIM_AI_BRK_NOT_OPEN],
                   ~ai_prev[1] & ai_status[`GIM_AI_BRK_NOT_OPEN],
                   ai_prev[0] & ~ai_status[`GIM_AI_MAINS],
                   ~ai_prev[0] & ai_status[`GIM_AI_MAINS],
                   lt_rise[`GIM_LT_SUPERVISOR],
                   lt_rise[`GIM_LT_SYNC],
                   lt_rise[`GIM_LT_BRK_NOT_OPEN],
                   serial_activate,
                   lt_rise[`GIM_LT_MAINS],
                   lt_all_prev & ~lt_inhibit,
                   lt_rise[`GIM_LT_CONTACT]};

   always @* begin
      take      = {NEV{1'b0}};
      next_code = 4'h0;
      for (k = NEV - 1; k >= 0; k = k - 1) begin
         if (pend[k]) begin
            take      = {NEV{1'b0}};
            take[k]   = 1'b1;
            next_code = k[3:0] + 4'h1;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         pend        <= {NEV{1'b0}};
         lt_prev     <= 6'h00;
         ai_prev     <= 2'h0;
         lt_all_prev <= 1'b0;
         event_valid <= 1'b0;
         event_code  <= 4'h0;
      end else begin
         lt_prev     <= lt_status;
         ai_prev     <= {ai_status[`GIM_AI_BRK_NOT_OPEN], ai_status[`GIM_AI_MAINS]};
         lt_all_prev <= lt_inhibit;
         pend        <= (pend & ~take) | raise;
         event_valid <= |take;
         event_code  <= next_code;
      end
   end

endmodule

/* File: tb/gim_host_model.sv */
// gim_host_model.sv: remote host that writes the serial holding registers.
// assumes one-cycle write strobes on ref_clk, changed on the falling edge.
`timescale 1ns/1ps
`include "gim_map.vh"

module gim_host_model (
   input  logic        ref_clk,
   output logic        reg_wr,
   output logic [15:0] reg_addr,
   output logic [15:0] reg_wdata
);
   // ********
   // write tasks
   // ********
   initial begin
      reg_wr = 1'h0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
   end

   // a released bus shows the inverse, so a stale word is never mistaken for a fresh one
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'h0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task cmd(input logic [15:0] pw, input logic [15:0] code);
      wr(`GIM_REG_PASSWORD, pw);
      wr(`GIM_REG_COMMAND, code);
   endtask
endmodule

/* File: tb/gim_inhibit_manager_checker.sv */
// gim_inhibit_manager_checker.sv: concurrent checks on the inhibit manager ports.
// assumes pins pass two flops inside the block before the logic sees them.
`timescale 1ns/1ps
`include "gim_map.vh"

module gim_inhibit_manager_checker (
   input logic       ref_clk,
   input logic       rst,
   input logic       contact_ai_inhibit,
   input logic       load_mgmt_request,
   input logic       load_inhibit_input_function,
   input logic       supervisor_request,
   input logic       sync_in_progress,
   input logic       generator_breaker_closed,
   input logic       auto_mode,
   input logic       ai_inhibit,
   input logic       lt_inhibit,
   input logic [4:0] ai_status,
   input logic [5:0] lt_status,
   input logic       generator_breaker_open_cmd,
   input logic       event_valid,
   input logic [3:0] event_code
);
   // ********
   // properties
   // ********
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_sync_open;
      (sync_in_progress && !generator_breaker_closed)[*4];
   endsequence
   sequence s_release_log;
      ##[0:12] (event_valid && event_code == `GIM_EVT_LT_RELEASE);
   endsequence

   a_contact_stop_flag:
      assert property (contact_ai_inhibit[*4] |-> ai_status[`GIM_AI_CONTACT])
      else $error("contact stop flag missing");
   a_load_mgmt_flag:
      assert property (load_mgmt_request[*4] |-> ai_status[`GIM_AI_LOAD_MGMT])
      else $error("load management flag missing");
   a_lt_contact_flag:
      assert property (load_inhibit_input_function[*4] |-> lt_status[`GIM_LT_CONTACT])
      else $error("load contact flag missing");
   a_supervisor_flag:
      assert property (supervisor_request[*4] |-> lt_status[`GIM_LT_SUPERVISOR])
      else $error("supervisor flag missing");
   a_sync_open_flag:
      assert property (s_sync_open |-> lt_status[`GIM_LT_SYNC])
      else $error("sync flag missing");
   a_lt_needs_source:
      assert property (lt_inhibit |-> (|lt_status))
      else $error("load inhibit without source");
   a_ai_needs_source:
      assert property (ai_inhibit |-> (|ai_status))
      else $error("stop inhibit without source");
   a_lt_in_auto:
      assert property (auto_mode[*6] ##0 (|lt_status) |-> lt_inhibit)
      else $error("load inhibit not raised in auto");
   a_open_follows:
      assert property (lt_inhibit |-> ##[0:2] generator_breaker_open_cmd)
      else $error("breaker open not commanded");
   a_release_logged:
      assert property ($fell(lt_inhibit) |-> s_release_log)
      else $error("release event missing");
endmodule

bind gim_inhibit_manager gim_inhibit_manager_checker u_chk (.*);

/* File: tb/testbench.sv */
// testbench.sv: directed scenarios for the genset inhibit manager.
// assumes the host model drives the register strobes and sec_tick is made here.
`timescale 1ns/1ps
`include "gim_map.vh"

module testbench;
   logic        ref_clk, rst, sec_tick;
   wire         reg_wr;
   wire  [15:0] reg_addr, reg_wdata;
   logic [15:0] password, seen;
   logic [7:0]  mains_fail_wait_s;
   logic        serial_enable_configured, serial_command_enable_input;
   logic        load_inhibit_input_function, contact_ai_inhibit, clock_ai_inhibit;
   logic        load_mgmt_request, parallel_only_plant, mains_in_tolerance;
   logic        brk_not_open_option, other_breaker_stuck, supervisor_request;
   logic        sync_in_progress, generator_breaker_closed, ramp_possible;
   logic        auto_mode, test_mode, remote_start_mode, event_valid;
   logic        ai_inhibit, lt_inhibit, generator_breaker_open_cmd, power_ramp_down;
   logic [3:0]  event_code;
   logic [4:0]  ai_status;
   logic [5:0]  lt_status;
   int          err_total, samples_checked;

   gim_host_model u_host (.*);
   gim_inhibit_manager u_dut (.*);

   // ********
   // helpers
   // ********
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) if (event_valid) seen[event_code] <= 1'h1;

   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // seconds run far faster than real time; only the tick count matters
   task sec(input int n);
      repeat (n) begin
         sec_tick = 1'h1;
         cyc(1);
         sec_tick = 1'h0;
         cyc(2);
      end
   endtask

   task chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task summarize;
      $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ********
   // scenarios
   // ********
   task t_serial;
      for (int i = 0; i < 2; i++) begin
         seen = 16'h0000;
         u_host.cmd(password, i ? `GIM_CMD_INHIBIT_B : `GIM_CMD_INHIBIT_A);
         cyc(8);
         chk(lt_status, 6'h04);
         chk({lt_inhibit, generator_breaker_open_cmd}, 2'h3);
         chk(seen[`GIM_EVT_LT_SERIAL], 1'h1);
         u_host.cmd(password, `GIM_CMD_RELEASE);
         cyc(8);
         chk(lt_inhibit, 1'h0);
         chk(seen[`GIM_EVT_LT_RELEASE], 1'h1);
      end
      $display("serial commands done");
   endtask

   task t_reject;
      u_host.wr(`GIM_REG_PASSWORD, password);
      u_host.wr(16'h0067, `GIM_CMD_INHIBIT_A);
      u_host.cmd(~password, `GIM_CMD_INHIBIT_A);
      u_host.wr(`GIM_REG_PASSWORD, password);
      sec(5);
      u_host.wr(`GIM_REG_COMMAND, `GIM_CMD_INHIBIT_A);
      serial_enable_configured = 1'h1;
      u_host.cmd(password, `GIM_CMD_INHIBIT_A);
      cyc(8);
      chk(lt_status, 6'h00);
      serial_command_enable_input = 1'h1;
      cyc(4);
      u_host.cmd(password, `GIM_CMD_INHIBIT_A);
      sec(24);
      u_host.wr(`GIM_REG_PASSWORD, password);
      sec(4);
      u_host.wr(`GIM_REG_COMMAND, `GIM_CMD_INHIBIT_A);
      sec(29);
      cyc(3);
      chk(lt_status[`GIM_LT_SERIAL], 1'h1);
      sec(1);
      cyc(3);
      chk(lt_status[`GIM_LT_SERIAL], 1'h0);
      $display("serial refusals and hold done");
   endtask

   task t_mains;
      seen = 16'h0000;
      parallel_only_plant = 1'h1;
      mains_in_tolerance = 1'h0;
      cyc(6);
      chk({lt_status[`GIM_LT_MAINS], generator_breaker_open_cmd}, 2'h3);
      sec(2);
      chk({ai_status[`GIM_AI_MAINS], ai_inhibit}, 2'h0);
      sec(1);
      cyc(3);
      chk({ai_status[`GIM_AI_MAINS], ai_inhibit}, 2'h3);
      mains_in_tolerance = 1'h1;
      cyc(8);
      chk({ai_status[`GIM_AI_MAINS], lt_status[`GIM_LT_MAINS]}, 2'h0);
      chk({seen[`GIM_EVT_LT_MAINS], seen[`GIM_EVT_AI_MAINS_ON], seen[`GIM_EVT_AI_MAINS_OFF]},
          3'h7);
      parallel_only_plant = 1'h0;
      $display("mains failure done");
   endtask

   task t_breaker;
      seen = 16'h0000;
      other_breaker_stuck = 1'h1;
      cyc(6);
      chk({ai_status[`GIM_AI_BRK_NOT_OPEN], lt_status[`GIM_LT_BRK_NOT_OPEN]}, 2'h0);
      brk_not_open_option = 1'h1;
      cyc(6);
      chk({ai_status[`GIM_AI_BRK_NOT_OPEN], lt_status[`GIM_LT_BRK_NOT_OPEN], ai_inhibit},
          3'h7);
      other_breaker_stuck = 1'h0;
      cyc(8);
      chk({seen[`GIM_EVT_AI_BRK_ON], seen[`GIM_EVT_LT_BRK], seen[`GIM_EVT_AI_BRK_OFF]},
          3'h7);
      $display("breaker not open done");
   endtask

   task t_sources;
      logic [5:0] v;
      seen = 16'h0000;
      for (int i = 0; i < 7; i++) begin
         v = 6'h01 << i;
         {supervisor_request, sync_in_progress, load_mgmt_request, clock_ai_inhibit,
          contact_ai_inhibit, load_inhibit_input_function} = v;
         cyc(6);
         chk({lt_status[5:4], ai_status[2:0], lt_status[0]}, v);
         chk({ai_inhibit, lt_inhibit}, {|v[3:1], v[0] | v[4] | v[5]});
      end
      chk({seen[`GIM_EVT_LT_SUPER], seen[`GIM_EVT_LT_SYNC], seen[`GIM_EVT_LT_CONTACT]},
          3'h7);
      generator_breaker_closed = 1'h1;
      ramp_possible = 1'h1;
      sync_in_progress = 1'h1;
      cyc(6);
      chk(lt_status, 6'h00);
      supervisor_request = 1'h1;
      cyc(8);
      chk({power_ramp_down, generator_breaker_open_cmd}, 2'h3);
      ramp_possible = 1'h0;
      cyc(2);
      chk({power_ramp_down, generator_breaker_open_cmd}, 2'h1);
      for (int m = 0; m < 4; m++) begin
         {remote_start_mode, test_mode, auto_mode} = (m == 0) ? 3'h0 : 3'h1 << (m - 1);
         contact_ai_inhibit = 1'h1;
         cyc(8);
         chk({lt_inhibit, ai_inhibit}, {m != 0, m == 1});
      end
      {remote_start_mode, test_mode, auto_mode, supervisor_request} = 4'h2;
      {sync_in_progress, contact_ai_inhibit, generator_breaker_closed} = 3'h0;
      $display("sources and modes done");
   endtask

   // ********
   // main sequence
   // ********
   initial begin
      {serial_enable_configured, serial_command_enable_input, load_inhibit_input_function,
       contact_ai_inhibit, clock_ai_inhibit, load_mgmt_request, parallel_only_plant,
       brk_not_open_option, other_breaker_stuck, supervisor_request, sync_in_progress,
       generator_breaker_closed, ramp_possible, test_mode, remote_start_mode} = 15'h0000;
      {rst, sec_tick, mains_in_tolerance, auto_mode} = 4'hB;
      password = 16'h5A3C;
      mains_fail_wait_s = 8'h03;
      seen = 16'h0000;
      err_total = 0;
      samples_checked = 0;
      cyc(10);
      rst = 1'h0;
      t_serial;
      t_reject;
      t_mains;
      t_breaker;
      t_sources;
      summarize;
   end

   // a few hundred cycles are expected, so 200 us means a hang
   initial begin
      #200000;
      err_total++;
      summarize;
   end
endmodule
